/* inc/devctl_cfg.svh */
// Purpose: constants for the device state control registers
// Assumes: 8-bit registers, 100 MHz core clock
// Notes:   offsets as printed; boot defaults come from straps caught after reset
`ifndef DEVCTL_CFG_SVH
`define DEVCTL_CFG_SVH
`define DEVCTL_ADDR_STATE        8'h3f
`define DEVCTL_ADDR_CONFIG       8'h40
`define DEVCTL_ADDR_STATUS       8'h50
`define DEVCTL_ADDR_LP_TIME      8'h51
// device_state_control fields
`define DEVCTL_BIT_SEQ_OFF       7
`define DEVCTL_BIT_CAL_PWDN      6
`define DEVCTL_BIT_CLK_SEL       5
`define DEVCTL_BIT_PORT_SEL      4
`define DEVCTL_BIT_OFF_RST       3
`define DEVCTL_BIT_STAY_ON       2
`define DEVCTL_BIT_SLEEP         1
`define DEVCTL_BIT_OFF           0
// device_config_control fields
`define DEVCTL_BIT_CONV_SLP      6
`define DEVCTL_BIT_SLOT_HI       5
`define DEVCTL_BIT_SLOT_LO       4
`define DEVCTL_BIT_SLP_POL       3
`define DEVCTL_BIT_LP_OFF        2
`define DEVCTL_BIT_OFF_CRST      1
`define DEVCTL_BIT_IRQ_POL       0
// reset values
`define DEVCTL_STATE_RESET       8'h10
`define DEVCTL_CONFIG_RESET      8'h34
// slot times in ns and cycle counts at the 10 ns clock period
`define DEVCTL_CLK_PERIOD_NS     10
`define DEVCTL_SLOT1_NS          200000
`define DEVCTL_SLOT2_NS          500000
`define DEVCTL_SLOT3_NS          2000000
`define DEVCTL_SLOT1_CYC         (`DEVCTL_SLOT1_NS / `DEVCTL_CLK_PERIOD_NS)
`define DEVCTL_SLOT2_CYC         (`DEVCTL_SLOT2_NS / `DEVCTL_CLK_PERIOD_NS)
`define DEVCTL_SLOT3_CYC         (`DEVCTL_SLOT3_NS / `DEVCTL_CLK_PERIOD_NS)
`define DEVCTL_LP_TIME_RESET     8'h08
`define DEVCTL_RESOURCES         4
`endif

/* inc/devctl_pkg.sv */
// Purpose: types shared by the device state control block
// Assumes: constants come from devctl_cfg.svh
// Notes:   none
package devctl_pkg;
  typedef enum logic [2:0] {
    ST_OFF,
    ST_UP,
    ST_ACTIVE,
    ST_SLEEP,
    ST_DOWN
  } pwr_state_e;
  typedef logic [7:0] reg8_t;
  typedef logic [3:0] res_t;
endpackage

/* hw/slot_timer.sv */
// Purpose: power sequencing slot timer
// Assumes: start is a one-cycle pulse, slot code sampled at start
// Notes:   code 00 gives an immediate done
`timescale 1ns/10ps
`include "devctl_cfg.svh"
module slot_timer (
  input  wire logic       core_clk_in,
  input  wire logic       reset_in,
  input  wire logic       start_in,
  input  wire logic [1:0] slot_code_in,
  output logic            done_out
);
  typedef struct packed {
    logic [17:0] cnt;
    logic        run;
    logic        done;
  } tmr_s;
  tmr_s s_q;
  tmr_s s_d;

  // cycles for a slot code; rounding down cannot arise, figures are exact
  function automatic logic [17:0] slot_cycles(input logic [1:0] code);
    logic [17:0] r;
    r = 18'h0_0000;
    case (code)
      2'b01:   r = 18'(`DEVCTL_SLOT1_CYC);
      2'b10:   r = 18'(`DEVCTL_SLOT2_CYC);
      2'b11:   r = 18'(`DEVCTL_SLOT3_CYC);
      default: r = 18'h0_0000;
    endcase
    return r;
  endfunction

  // countdown, done is a one-cycle pulse when the slot ends
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start_in)
    begin
      s_d.cnt = slot_cycles(slot_code_in);
      s_d.run = 1'b1;
    end
    else if (s_q.run)
    begin
      if (s_q.cnt <= 18'h0_0001)
      begin
        s_d.run  = 1'b0;
        s_d.done = 1'b1;
      end
      else
      begin
        s_d.cnt = s_q.cnt - 18'h0_0001;
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign done_out = s_q.done;
endmodule

/* hw/device_state_control_regs.sv */
// Purpose: device state control and configuration registers with power state machine
// Assumes: register port strobes are one cycle, inputs synchronous to core_clk_in
// Notes:   boot straps are caught in the cycle after reset releases
`timescale 1ns/10ps
`include "devctl_cfg.svh"
module device_state_control_regs (
  input  wire logic                 core_clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 backup_entry_in,
  input  wire logic [7:0]           addr_in,
  input  wire logic [7:0]           wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic      [7:0]           rdata_out,
  input  wire logic [7:0]           boot_state_in,
  input  wire logic [7:0]           boot_config_in,
  input  wire logic                 sleep_request_in,
  input  wire logic                 power_button_input,
  input  wire logic                 irq_request_in,
  output logic                      irq_output_pin,
  output logic [`DEVCTL_RESOURCES-1:0] resource_en_out,
  output logic                      core_reset_out,
  output logic                      calendar_clk_gate_out,
  output logic                      calendar_reset_out,
  output logic                      slow_clock_rc_sel_out,
  output logic                      scaling_port_ctl_out,
  output logic                      converter_sleep_level_out,
  output logic                      sleep_state_out
);
  typedef struct packed {
    devctl_pkg::reg8_t      st_reg;
    devctl_pkg::reg8_t      cfg_reg;
    devctl_pkg::reg8_t      lp_time;
    devctl_pkg::reg8_t      rdata;
    devctl_pkg::pwr_state_e state;
    devctl_pkg::res_t       res_on;
    logic                   seq_busy;
    logic                   boot_pend;
    logic                   off_rst_latch;
    logic                   core_rst;
    logic [7:0]             lp_cnt;
    logic [15:0]            lp_pre;
    logic                   slot_start;
  } ctl_s;

  ctl_s s_q;
  ctl_s s_d;
  logic slot_done;
  logic sleep_active;
  logic off_pending;

  // ==========================================================
  // slot timer
  // ==========================================================
  slot_timer u_slot (
    .core_clk_in  (core_clk_in),
    .reset_in     (reset_in),
    .start_in     (s_q.slot_start),
    .slot_code_in (s_q.cfg_reg[`DEVCTL_BIT_SLOT_HI:`DEVCTL_BIT_SLOT_LO]),
    .done_out     (slot_done)
  );

  // ==========================================================
  // helpers
  // ==========================================================
  // reads a register by address; unmapped addresses read zero
  function automatic devctl_pkg::reg8_t read_mux(input logic [7:0] a, input ctl_s s);
    devctl_pkg::reg8_t r;
    r = 8'h00;
    if (a == `DEVCTL_ADDR_STATE)
      r = s.st_reg;
    else if (a == `DEVCTL_ADDR_CONFIG)
      r = {1'b0, s.cfg_reg[6:0]};
    else if (a == `DEVCTL_ADDR_STATUS)
      r = {4'h0, s.res_on[1:0], 2'(s.state == devctl_pkg::ST_SLEEP ? 2'b11 :
                                   (s.state == devctl_pkg::ST_OFF ? 2'b00 : 2'b01))};
    else if (a == `DEVCTL_ADDR_LP_TIME)
      r = s.lp_time;
    else
      r = 8'h00;
    return r;
  endfunction

  // level of the sleep pin after polarity
  assign sleep_active = s_q.cfg_reg[`DEVCTL_BIT_SLP_POL] ? sleep_request_in
                                                        : ~sleep_request_in;
  assign off_pending  = s_q.st_reg[`DEVCTL_BIT_OFF] | s_q.st_reg[`DEVCTL_BIT_OFF_RST];

  // ==========================================================
  // next-state logic
  // ==========================================================
  always_comb
  begin
    s_d = s_q;
    s_d.slot_start = 1'b0;
    s_d.rdata = 8'h00;
    // boot straps replace configured defaults once, after reset release
    if (s_q.boot_pend)
    begin
      s_d.boot_pend = 1'b0;
      s_d.st_reg[`DEVCTL_BIT_CLK_SEL] = boot_state_in[`DEVCTL_BIT_CLK_SEL];
      s_d.st_reg[`DEVCTL_BIT_STAY_ON] = boot_state_in[`DEVCTL_BIT_STAY_ON];
      s_d.cfg_reg[`DEVCTL_BIT_SLOT_HI:`DEVCTL_BIT_SLOT_LO] =
        boot_config_in[`DEVCTL_BIT_SLOT_HI:`DEVCTL_BIT_SLOT_LO];
      s_d.cfg_reg[`DEVCTL_BIT_LP_OFF]   = boot_config_in[`DEVCTL_BIT_LP_OFF];
      s_d.cfg_reg[`DEVCTL_BIT_OFF_CRST] = boot_config_in[`DEVCTL_BIT_OFF_CRST];
      s_d.cfg_reg[`DEVCTL_BIT_IRQ_POL]  = boot_config_in[`DEVCTL_BIT_IRQ_POL];
    end
    // register writes
    if (wr_in)
    begin
      if (addr_in == `DEVCTL_ADDR_STATE)
      begin
        s_d.st_reg = wdata_in;
        if (wdata_in[`DEVCTL_BIT_OFF_RST])
          s_d.off_rst_latch = 1'b1;
      end
      else if (addr_in == `DEVCTL_ADDR_CONFIG)
        s_d.cfg_reg = {1'b0, wdata_in[6:0]};
      else if (addr_in == `DEVCTL_ADDR_LP_TIME)
        s_d.lp_time = wdata_in;
    end
    if (rd_in)
      s_d.rdata = read_mux(addr_in, s_q);
    // backup entry leaves the calendar power-down bit alone
    if (backup_entry_in)
      s_d.st_reg[`DEVCTL_BIT_CAL_PWDN] = s_q.st_reg[`DEVCTL_BIT_CAL_PWDN];
    // long press counter: prescaler ticks once per 65536 cycles
    if (power_button_input == 1'b0)
    begin
      s_d.lp_pre = s_q.lp_pre + 16'h0001;
      if (s_q.lp_pre == 16'hffff && s_q.lp_cnt != 8'hff)
        s_d.lp_cnt = s_q.lp_cnt + 8'h01;
    end
    else
    begin
      s_d.lp_pre = 16'h0000;
      s_d.lp_cnt = 8'h00;
    end
    // power state machine
    case (s_q.state)
      devctl_pkg::ST_OFF:
      begin
        s_d.res_on = '0;
        // latch stays set while OFF so the requested core reset is held, not pulsed
        s_d.core_rst = s_q.off_rst_latch | s_q.cfg_reg[`DEVCTL_BIT_OFF_CRST];
        if (s_q.st_reg[`DEVCTL_BIT_STAY_ON] && !off_pending && !wr_in)
        begin
          s_d.off_rst_latch = 1'b0;
          s_d.core_rst   = 1'b0;
          s_d.state      = devctl_pkg::ST_UP;
          s_d.slot_start = 1'b1;
          s_d.seq_busy   = 1'b1;
        end
      end
      devctl_pkg::ST_UP:
      begin
        if (s_q.seq_busy && slot_done)
        begin
          s_d.res_on = {s_q.res_on[`DEVCTL_RESOURCES-2:0], 1'b1};
          if (s_q.res_on[`DEVCTL_RESOURCES-2])
          begin
            s_d.state    = devctl_pkg::ST_ACTIVE;
            s_d.seq_busy = 1'b0;
          end
          else
            s_d.slot_start = 1'b1;
        end
      end
      devctl_pkg::ST_ACTIVE, devctl_pkg::ST_SLEEP:
      begin
        if (off_pending ||
            (s_q.cfg_reg[`DEVCTL_BIT_LP_OFF] && s_q.lp_cnt >= s_q.lp_time))
        begin
          s_d.state = devctl_pkg::ST_DOWN;
          if (s_q.st_reg[`DEVCTL_BIT_SEQ_OFF])
            s_d.slot_start = 1'b1;
          else
            s_d.res_on = '0;
        end
        else if (s_q.state == devctl_pkg::ST_ACTIVE)
        begin
          if (s_q.st_reg[`DEVCTL_BIT_SLEEP] && sleep_active)
            s_d.state = devctl_pkg::ST_SLEEP;
        end
        else if (!s_q.st_reg[`DEVCTL_BIT_SLEEP] || !sleep_active)
          s_d.state = devctl_pkg::ST_ACTIVE;
      end
      devctl_pkg::ST_DOWN:
      begin
        if (s_q.res_on == '0)
        begin
          s_d.state = devctl_pkg::ST_OFF;
          // turn-off reset domain
          s_d.st_reg[`DEVCTL_BIT_OFF]     = 1'b0;
          s_d.st_reg[`DEVCTL_BIT_SLEEP]   = 1'b0;
          s_d.st_reg[`DEVCTL_BIT_OFF_RST] = 1'b0;
          s_d.st_reg[`DEVCTL_BIT_STAY_ON] = 1'b0;
          s_d.cfg_reg[`DEVCTL_BIT_SLOT_HI:`DEVCTL_BIT_SLOT_LO] =
            boot_config_in[`DEVCTL_BIT_SLOT_HI:`DEVCTL_BIT_SLOT_LO];
        end
        else if (slot_done)
        begin
          s_d.res_on = {1'b0, s_q.res_on[`DEVCTL_RESOURCES-1:1]};
          if (s_q.res_on[`DEVCTL_RESOURCES-1:1] != '0)
            s_d.slot_start = 1'b1;
        end
      end
      default:
        s_d.state = devctl_pkg::ST_OFF;
    endcase
  end

  // ==========================================================
  // state register, general reset
  // ==========================================================
  // general reset clears everything but st_reg, cfg_reg, lp_time and boot_pend, which load defaults; turn-off fields are handled on OFF entry
  always_ff @(posedge core_clk_in)
  begin
    if (reset_in)
    begin
      s_q         <= '0;
      s_q.st_reg  <= `DEVCTL_STATE_RESET;
      s_q.cfg_reg <= `DEVCTL_CONFIG_RESET;
      s_q.lp_time <= `DEVCTL_LP_TIME_RESET;
      s_q.boot_pend <= 1'b1;
      s_q.state   <= devctl_pkg::ST_OFF;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign rdata_out                 = s_q.rdata;
  assign resource_en_out           = s_q.res_on;
  assign core_reset_out            = s_q.core_rst;
  assign calendar_clk_gate_out     = s_q.st_reg[`DEVCTL_BIT_CAL_PWDN];
  assign calendar_reset_out        = s_q.st_reg[`DEVCTL_BIT_CAL_PWDN];
  assign slow_clock_rc_sel_out     = s_q.st_reg[`DEVCTL_BIT_CLK_SEL];
  assign scaling_port_ctl_out      = s_q.st_reg[`DEVCTL_BIT_PORT_SEL];
  assign converter_sleep_level_out = s_q.cfg_reg[`DEVCTL_BIT_CONV_SLP] &&
                                     s_q.state == devctl_pkg::ST_SLEEP;
  assign sleep_state_out           = s_q.state == devctl_pkg::ST_SLEEP;
  assign irq_output_pin            = irq_request_in ^ ~s_q.cfg_reg[`DEVCTL_BIT_IRQ_POL];
endmodule

/* test/devctl_checker_sva.sv */
// Purpose: port-level checks on the device state control registers
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the block at the foot of this file
`timescale 1ns/10ps
module devctl_checker (
  input wire logic       core_clk_in,
  input wire logic       reset_in,
  input wire logic       backup_entry_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       irq_request_in,
  input wire logic       irq_output_pin,
  input wire logic [3:0] resource_en_out,
  input wire logic       core_reset_out,
  input wire logic       calendar_clk_gate_out,
  input wire logic       calendar_reset_out,
  input wire logic       slow_clock_rc_sel_out,
  input wire logic       scaling_port_ctl_out,
  input wire logic       converter_sleep_level_out,
  input wire logic       sleep_state_out
);
  // =====================================================
  // write decode, shared by several properties
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  wire st_wr = wr_in && (addr_in == 8'h3f);
  wire cf_wr = wr_in && (addr_in == 8'h40);
  // =====================================================
  // assertions
  rdata_idle_a: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside read answer");
  cfg_msb_zero_a: assert property (rd_in && addr_in == 8'h40 |=> !rdata_out[7])
    else $error("config bit 7 read as one");
  cal_pair_a: assert property (calendar_clk_gate_out == calendar_reset_out)
    else $error("calendar gate and reset disagree");
  cal_write_a: assert property (st_wr |=> calendar_clk_gate_out == $past(wdata_in[6]))
    else $error("calendar gate not following write");
  cal_backup_a: assert property (backup_entry_in && !st_wr |=> $stable(calendar_clk_gate_out))
    else $error("calendar bit disturbed by backup entry");
  clk_sel_write_a: assert property (st_wr |=> slow_clock_rc_sel_out == $past(wdata_in[5]))
    else $error("clock source select not following write");
  port_sel_write_a: assert property (st_wr |=> scaling_port_ctl_out == $past(wdata_in[4]))
    else $error("scaling port select not following write");
  irq_pol_a: assert property (cf_wr ##1 !cf_wr |-> irq_output_pin == (irq_request_in ^ !$past(wdata_in[0])))
    else $error("interrupt pin polarity wrong");
  conv_sleep_a: assert property (converter_sleep_level_out |-> sleep_state_out)
    else $error("converter sleep level outside sleep");
  // main scenarios reached
  sleep_c: cover property ($rose(sleep_state_out));
  full_on_c: cover property (resource_en_out == 4'hf);
  core_rst_c: cover property ($rose(core_reset_out));
endmodule

bind device_state_control_regs devctl_checker u_chk (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .backup_entry_in(backup_entry_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_request_in(irq_request_in),
  .irq_output_pin(irq_output_pin), .resource_en_out(resource_en_out), .core_reset_out(core_reset_out),
  .calendar_clk_gate_out(calendar_clk_gate_out), .calendar_reset_out(calendar_reset_out),
  .slow_clock_rc_sel_out(slow_clock_rc_sel_out), .scaling_port_ctl_out(scaling_port_ctl_out),
  .converter_sleep_level_out(converter_sleep_level_out), .sleep_state_out(sleep_state_out));

/* test/host_port_model.sv */
// Purpose: host side of the register port
// Assumes: slave never stalls, read data one cycle after the strobe
// Notes:   each write leaves one idle edge before the next access, each read two
`timescale 1ns/10ps
module host_port_model (
  input  wire logic       core_clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out
);
  // =====================================================
  // idle bus at time zero
  initial
  begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  // one-cycle write strobe
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge core_clk_in);
    wr_out <= 1'b0;
  endtask
  // data is only valid in the cycle after the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge core_clk_in);
    rd_out <= 1'b0;
    @(posedge core_clk_in);
    d = rdata_in;
  endtask
endmodule

/* test/device_state_control_regs_tb_top.sv */
// Purpose: self-checking bench for the device state control registers
// Assumes: straps select zero-length slots so sequencing is short
// Notes:   status register used to observe sleep and active states
`timescale 1ns/10ps
module device_state_control_regs_tb_top;
  logic       core_clk_in = 1'b0;
  logic       reset_in = 1'b1;
  logic       backup_entry_in = 1'b0;
  logic       sleep_request_in = 1'b0;
  logic       irq_request_in = 1'b0;
  logic [7:0] addr, wdata, rdata_out, rv;
  logic       wr, rd, irq_output_pin, core_reset_out, cal_gate, cal_rst, rc_sel, port_ctl, conv_lvl, sleep_st;
  logic [3:0] resource_en_out;
  logic       mid_seen;
  int         miscompares = 0;
  int         total_checks = 0;
  // =====================================================
  // clock, host model and block
  always #5 core_clk_in = ~core_clk_in;
  host_port_model u_host (.core_clk_in(core_clk_in), .rdata_in(rdata_out), .addr_out(addr), .wdata_out(wdata),
    .wr_out(wr), .rd_out(rd));
  device_state_control_regs u_dut (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .backup_entry_in(backup_entry_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata_out), .boot_state_in(8'h20), .boot_config_in(8'h07), .sleep_request_in(sleep_request_in),
    .power_button_input(1'b1), .irq_request_in(irq_request_in), .irq_output_pin(irq_output_pin),
    .resource_en_out(resource_en_out), .core_reset_out(core_reset_out), .calendar_clk_gate_out(cal_gate),
    .calendar_reset_out(cal_rst), .slow_clock_rc_sel_out(rc_sel), .scaling_port_ctl_out(port_ctl),
    .converter_sleep_level_out(conv_lvl), .sleep_state_out(sleep_st));
  // =====================================================
  // checking helpers
  task automatic report_and_stop;
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // polling bounds a slow state change instead of guessing its latency
  task automatic poll(input logic [7:0] a, input logic [7:0] exp);
    for (int n = 0; n < 40; n++)
    begin
      u_host.read_reg(a, rv);
      if (rv === exp)
        break;
    end
    chk($sformatf("register %h", a), exp, rv);
  endtask
  // notes whether a partial resource set was ever seen on the way
  task automatic wait_res(input logic [3:0] exp);
    int n;
    mid_seen = 1'b0;
    for (n = 0; n < 30000 && resource_en_out !== exp; n++)
    begin
      @(posedge core_clk_in);
      if (resource_en_out !== 4'h0 && resource_en_out !== 4'hf)
        mid_seen = 1'b1;
    end
    if (n == 30000)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask
  // =====================================================
  // main sequence
  initial
  begin
    repeat (5) @(posedge core_clk_in);
    reset_in <= 1'b0;
    @(posedge core_clk_in);
    poll(8'h3f, 8'h30);
    poll(8'h40, 8'h07);
    u_host.write_reg(8'h40, 8'hff);
    poll(8'h40, 8'h7f);
    u_host.write_reg(8'h40, 8'h48);
    irq_request_in <= 1'b1;
    @(posedge core_clk_in);
    chk("irq pin", 8'h00, 8'(irq_output_pin));
    chk("rc select", 8'h01, 8'(rc_sel));
    poll(8'h7e, 8'h00);
    u_host.write_reg(8'h3f, 8'h04);
    wait_res(4'hf);
    chk("port select", 8'h00, 8'(port_ctl));
    sleep_request_in <= 1'b1;
    u_host.write_reg(8'h3f, 8'h06);
    poll(8'h50, 8'h0f);
    chk("sleep level", 8'h01, 8'(conv_lvl));
    u_host.write_reg(8'h3f, 8'h04);
    poll(8'h50, 8'h0d);
    u_host.write_reg(8'h3f, 8'h85);
    wait_res(4'h0);
    chk("ordered drop", 8'h01, 8'(mid_seen));
    poll(8'h3f, 8'h80);
    chk("core reset", 8'h00, 8'(core_reset_out));
    u_host.write_reg(8'h3f, 8'h04);
    wait_res(4'hf);
    u_host.write_reg(8'h40, 8'h18);
    u_host.write_reg(8'h3f, 8'h08);
    wait_res(4'h0);
    chk("joint drop", 8'h00, 8'(mid_seen));
    poll(8'h3f, 8'h00);
    chk("core reset", 8'h01, 8'(core_reset_out));
    poll(8'h40, 8'h08);
    u_host.write_reg(8'h3f, 8'h40);
    @(posedge core_clk_in);
    chk("calendar gate", 8'h01, 8'(cal_gate));
    chk("calendar reset", 8'h01, 8'(cal_rst));
    backup_entry_in <= 1'b1;
    poll(8'h3f, 8'h40);
    backup_entry_in <= 1'b0;
    report_and_stop();
  end
endmodule
